//--- rtl/timer_b_channel.v
/*
 * One channel of a 16-bit general timer: event counter mode and
 * pulse period / pulse width measurement mode, with an APB slave.
 * Assumes a 100 MHz system clock, a synchronous active-high reset,
 * an asynchronous measured/event pin and an asynchronous sub-clock pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timer_b_defs.vh"

module timer_b_channel (
	input  wire        i_clock,
	input  wire        i_rst,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire        i_channel_input_pin,
	input  wire        i_sub_clock,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	output reg         o_irq
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------

	// Address match, used for both reads and writes
	function addr_is;
		input [11:0] addr;
		input [11:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// Map an edge selection onto a pair of detected edges
	function edge_hit;
		input [1:0] sel;
		input       rise;
		input       fall;
		begin
			case (sel)
				`EDGE_FALL: edge_hit = fall;
				`EDGE_RISE: edge_hit = rise;
				`EDGE_BOTH: edge_hit = rise | fall;
				default:    edge_hit = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Registers and internal state
	// ----------------------------------------------------------------
	reg  [15:0] counter;
	reg  [15:0] reload;
	reg  [7:0]  channel_mode_reg;
	reg         run_flag;
	reg         overflow_flag;
	reg         seen_first;
	reg  [4:0]  prescale;
	reg  [4:0]  sub_div;
	reg         sub_level;
	reg         pin_level;
	reg         pin_prev;
	reg         sub_prev;

	wire [1:0] sync_in;
	wire [1:0] sync_s2;
	wire [1:0] sync_s3;

	wire [1:0] op_mode;
	wire [1:0] edge_sel;
	wire [1:0] clk_sel;
	wire       is_event;
	wire       is_measure;

	wire       bus_setup;
	wire       bus_done;
	wire       wr_counter;
	wire       wr_mode;
	wire       wr_run;
	wire       addr_ok;

	wire       pin_rise;
	wire       pin_fall;
	wire       sub_rise;
	wire       event_edge;
	wire       meas_edge;
	reg        count_tick;

	reg  [15:0] next_counter;
	reg  [15:0] next_reload;
	reg         next_irq;
	reg         next_overflow;
	reg         next_seen_first;
	reg  [31:0] read_data;

	// ----------------------------------------------------------------
	// Mode field decode
	// ----------------------------------------------------------------

	assign op_mode    = {channel_mode_reg[`MODE_OP_LO], channel_mode_reg[`MODE_OP_HI]};
	assign edge_sel   = {channel_mode_reg[`MODE_SEL_LO], channel_mode_reg[`MODE_SEL_HI]};
	assign clk_sel    = {channel_mode_reg[`MODE_CLK_LO], channel_mode_reg[`MODE_CLK_HI]};
	assign is_event   = (op_mode == `OP_EVENT);
	assign is_measure = (op_mode == `OP_MEASURE);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	assign sync_in = {i_sub_clock, i_channel_input_pin};

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			reg s1;
			reg s2;
			reg s3;
			// Stage one feeds only stage two, keeping metastability contained
			always @(posedge i_clock) begin
				if (i_rst) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else begin
					s1 <= sync_in[g];
					s2 <= s1;
					s3 <= s2;
				end
			end
			assign sync_s2[g] = s2;
			assign sync_s3[g] = s3;
		end
	endgenerate

	always @(posedge i_clock) begin
		if (i_rst) begin
			pin_level <= 1'b0;
			pin_prev  <= 1'b0;
			sub_level <= 1'b0;
			sub_prev  <= 1'b0;
		end else begin
			if (sync_s2[0] == sync_s3[0]) begin
				pin_level <= sync_s3[0];
			end
			if (sync_s2[1] == sync_s3[1]) begin
				sub_level <= sync_s3[1];
			end
			pin_prev <= pin_level;
			sub_prev <= sub_level;
		end
	end

	// edge detection on the filtered level
	assign pin_rise = pin_level & ~pin_prev;
	assign pin_fall = ~pin_level & pin_prev;
	assign sub_rise = sub_level & ~sub_prev;

	assign event_edge = edge_hit(edge_sel, pin_rise, pin_fall);

	// period uses falling edges, width uses both
	assign meas_edge = edge_sel[`MEAS_WIDTH_BIT] ? (pin_rise | pin_fall) : pin_fall;

	// ----------------------------------------------------------------
	// Count clock prescaler
	// ----------------------------------------------------------------

	// Free running dividers so the tick phase does not depend on run flag
	always @(posedge i_clock) begin
		if (i_rst) begin
			prescale <= `PRE_RESET;
			sub_div  <= `PRE_RESET;
		end else begin
			prescale <= prescale + `PRE_ONE;
			if (sub_rise) begin
				sub_div <= sub_div + `PRE_ONE;
			end
		end
	end

	// one cycle tick at the selected rate
	always @* begin
		case (clk_sel)
			`CLK_F1:   count_tick = 1'b1;
			`CLK_F8:   count_tick = (prescale[2:0] == `PRE_F8_END);
			`CLK_F32:  count_tick = (prescale == `PRE_F32_END);
			`CLK_SUB_CLOCK_DIV32: count_tick = sub_rise & (sub_div == `PRE_F32_END);
			default:   count_tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------

	// One wait state: pready rises on the second access cycle
	assign bus_setup  = i_psel & i_penable & ~o_pready;
	assign bus_done   = i_psel & i_penable & o_pready;
	assign addr_ok    = addr_is(i_paddr, `ADDR_COUNTER) | addr_is(i_paddr, `ADDR_MODE) |
	                    addr_is(i_paddr, `ADDR_RUN);
	assign wr_counter = bus_done & i_pwrite & addr_is(i_paddr, `ADDR_COUNTER);
	assign wr_mode    = bus_done & i_pwrite & addr_is(i_paddr, `ADDR_MODE);
	assign wr_run     = bus_done & i_pwrite & addr_is(i_paddr, `ADDR_RUN);

	// Read multiplexer
	always @* begin
		read_data = `DATA_ZERO;
		if (addr_is(i_paddr, `ADDR_COUNTER)) begin
			// capture valid only after second edge
			if (is_measure) begin
				read_data[15:0] = reload;
			end else begin
				read_data[15:0] = counter;
			end
		end else if (addr_is(i_paddr, `ADDR_MODE)) begin
			read_data[7:0] = channel_mode_reg;
			read_data[`MODE_OVF_BIT] = overflow_flag;
		end else if (addr_is(i_paddr, `ADDR_RUN)) begin
			read_data[0] = run_flag;
		end
	end

	// Bus answer, registered so all outputs come from flops
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= `DATA_ZERO;
		end else begin
			o_pready  <= bus_setup;
			o_pslverr <= bus_setup & ~addr_ok;
			if (bus_setup) begin
				o_prdata <= read_data;
			end
		end
	end

	// Control registers written by software
	always @(posedge i_clock) begin
		if (i_rst) begin
			channel_mode_reg <= `MODE_RESET;
			run_flag         <= 1'b0;
		end else begin
			if (wr_mode) begin
				channel_mode_reg <= i_pwdata[7:0] & `MODE_WMASK;
			end
			if (wr_run) begin
				run_flag <= i_pwdata[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter core
	// ----------------------------------------------------------------

	// Next state of counter, reload, flags and request
	always @* begin
		next_counter    = counter;
		next_reload     = reload;
		next_irq        = 1'b0;
		next_overflow   = overflow_flag;
		next_seen_first = seen_first;

		// mode write while running clears overflow
		if (wr_mode & run_flag) begin
			next_overflow = 1'b0;
		end

		// halted counter forgets the first edge
		if (!run_flag) begin
			next_seen_first = 1'b0;
		end

		if (is_event) begin
			if (run_flag & event_edge) begin
				if (counter == `CNT_ZERO) begin
					// period is reload plus one edges
					next_counter = reload;
					next_irq     = 1'b1;
				end else begin
					next_counter = counter - `CNT_ONE;
				end
			end
			if (wr_counter) begin
				next_reload = i_pwdata[15:0];
				if (!run_flag) begin
					next_counter = i_pwdata[15:0];
				end
			end
		end else if (is_measure) begin
			if (run_flag) begin
				if (meas_edge) begin
					next_reload     = counter;
					next_counter    = `CNT_ZERO;
					next_seen_first = 1'b1;
					next_irq        = seen_first;
				end else if (count_tick) begin
					next_counter = counter + `CNT_ONE;
					if (counter == `CNT_MAX) begin
						// overflow sets flag and requests; set beats clear
						next_overflow = 1'b1;
						next_irq      = 1'b1;
					end
				end
			end
		end else begin
			// Plain timer mode is outside this channel; writes still land
			if (wr_counter) begin
				next_reload = i_pwdata[15:0];
				if (!run_flag) begin
					next_counter = i_pwdata[15:0];
				end
			end
		end
	end

	// Core state registers
	always @(posedge i_clock) begin
		if (i_rst) begin
			counter       <= `CNT_RESET;
			reload        <= `CNT_RESET;
			overflow_flag <= 1'b0;
			seen_first    <= 1'b0;
			o_irq         <= 1'b0;
		end else begin
			counter       <= next_counter;
			reload        <= next_reload;
			overflow_flag <= next_overflow;
			seen_first    <= next_seen_first;
			o_irq         <= next_irq;
		end
	end

endmodule // timer_b_channel
`default_nettype wire

//--- rtl/timer_b_defs.vh
/*
 * Constants for the timer B event counter and pulse measurement channel:
 * register offsets, field positions, mode codes, reset values, timing.
 * Assumes it is included by bare name from the channel module only.
 */
`ifndef TIMER_B_DEFS_VH
`define TIMER_B_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADDR_COUNTER      12'h000
`define ADDR_MODE         12'h004
`define ADDR_RUN          12'h008
`define ADDR_LSB          11
`define ADDR_MSB          0

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_OP_LO        1
`define MODE_OP_HI        0
`define MODE_SEL_LO       3
`define MODE_SEL_HI       2
`define MODE_OVF_BIT      5
`define MODE_CLK_LO       7
`define MODE_CLK_HI       6
`define MODE_WMASK        8'hcf
`define MODE_RESET        8'h00

`define OP_TIMER          2'h0
`define OP_EVENT          2'h1
`define OP_MEASURE        2'h2

`define EDGE_FALL         2'h0
`define EDGE_RISE         2'h1
`define EDGE_BOTH         2'h2

`define MEAS_WIDTH_BIT    0

`define CLK_F1            2'h0
`define CLK_F8            2'h1
`define CLK_F32           2'h2
`define CLK_SUB_CLOCK_DIV32          2'h3

// ----------------------------------------------------------------
// Widths, reset values and divider counts
// ----------------------------------------------------------------
`define CNT_RESET         16'h0000
`define CNT_ZERO          16'h0000
`define CNT_ONE           16'h0001
`define CNT_MAX           16'hffff
`define PRE_RESET         5'h00
`define PRE_ONE           5'h01
`define PRE_F8_END        3'h7
`define PRE_F32_END       5'h1f
`define DATA_ZERO         32'h00000000

`endif

//--- bench/timer_b_channel_properties.sv
/* Port-level checks of the timer channel: APB timing and decode, irq pulse.
   Assumes it is bound to timer_b_channel and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module timer_b_channel_checker (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        i_channel_input_pin,
	input wire logic        i_sub_clock,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// One wait state, then a single ready pulse caused by an access
	ready_wait_a: assert property (i_psel && i_penable && !o_pready && !$past(i_penable)
		|=> o_pready) else $error("ready late");
	ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
	ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
		else $error("ready unasked");
	// Decode: only the three words are mapped
	err_unmapped_a: assert property (o_pready && i_paddr > 12'h008 |-> o_pslverr)
		else $error("no error");
	err_mapped_a: assert property (o_pready && (i_paddr == 12'h000 || i_paddr == 12'h004
		|| i_paddr == 12'h008) |-> !o_pslverr) else $error("false error");
	err_data_a: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
		else $error("error data");
	// Unused upper bits read zero, bit 4 of mode too
	cnt_width_a: assert property (o_pready && !i_pwrite && i_paddr == 12'h000
		|-> o_prdata[31:16] == 16'h0) else $error("counter bits");
	mode_bits_a: assert property (o_pready && !i_pwrite && i_paddr == 12'h004
		|-> o_prdata[31:8] == 24'h0 && !o_prdata[4]) else $error("mode bits");
	run_bits_a: assert property (o_pready && !i_pwrite && i_paddr == 12'h008
		|-> o_prdata[31:1] == 31'h0) else $error("run bits");
	irq_pulse_a: assert property (o_irq |=> !o_irq) else $error("irq held");
	cover property (o_irq);
	cover property (o_pready && o_pslverr);
	cover property (o_pready && i_pwrite);
endmodule // timer_b_channel_checker

bind timer_b_channel timer_b_channel_checker u_chk (.i_clock(i_clock), .i_rst(i_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .i_channel_input_pin(i_channel_input_pin),
	.i_sub_clock(i_sub_clock), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_irq(o_irq));
`default_nettype wire

//--- bench/pulse_source.sv
/* Far-side pulse source: square wave of half period i_half while i_on.
   Assumes the bench keeps i_half at 3 or more so each level is accepted. */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Source
// ----------------------------------------------------------------
module pulse_source (
	input wire logic       i_clock,
	input wire logic       i_on,
	input wire logic [7:0] i_half,
	output wire logic      o_pin
);
	logic [7:0] cnt = 8'h00;
	// One procedural driver for the level, idle low like the channel's reset
	logic       lvl = 1'b0;
	assign o_pin = lvl;
	// Level holds when idle, as a real driver would
	always @(posedge i_clock) begin
		if (i_on && cnt == i_half - 8'h01) begin
			cnt <= 8'h00;
			lvl <= ~lvl;
		end else
			cnt <= i_on ? cnt + 8'h01 : 8'h00;
	end
endmodule // pulse_source
`default_nettype wire

//--- bench/tb_timer_b_channel.sv
/* Self-checking bench of the timer channel: APB master tasks and scenarios.
   Assumes the checker is bound and pulse_source drives the channel pin. */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb_timer_b_channel;
	logic        i_clock = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, src_on = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, q, r;
	logic [7:0]  src_half = 8'h0a;
	logic [4:0]  sub_cnt = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, pin;
	int          bad_count = 0, tests_run = 0, irqs = 0, base;
	initial forever #5 i_clock = ~i_clock;
	// Slow sub-clock and interrupt tally
	always @(posedge i_clock) begin
		sub_cnt <= sub_cnt + 5'h01;
		if (irq === 1'b1) irqs <= irqs + 1;
	end
	timer_b_channel DUT (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_channel_input_pin(pin),
		.i_sub_clock(sub_cnt[2]), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq));
	pulse_source src (.i_clock(i_clock), .i_on(src_on), .i_half(src_half), .o_pin(pin));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Master holds the request until ready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge i_clock);
		pen <= 1;
		// No cycle count assumed: only the watchdog ends a hung wait
		do @(posedge i_clock); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 0; pen <= 0;
	endtask
	// k full periods from low: k rises, k falls, then settle
	task pulses(input int k, input logic [7:0] h);
		@(posedge i_clock);
		src_half <= h; src_on <= 1;
		repeat (2 * k * h) @(posedge i_clock);
		src_on <= 0;
		repeat (12) @(posedge i_clock);
	endtask
	task t_reset;
		apb(0, 12'h000, 0); chk(q, 0); chk(err, 0);
		apb(0, 12'h004, 0); chk(q, 0);
		apb(0, 12'h008, 0); chk(q, 0);
		apb(1, 12'h010, 32'hffff); chk(err, 1);
		apb(0, 12'h010, 0); chk(q, 0); chk(err, 1);
	endtask
	// Each edge select: reload 3, six counted edges leave 1 and one irq
	task t_event;
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h008, 0); apb(1, 12'h004, {28'h0, i[1:0], 2'b01});
			apb(1, 12'h000, 3); apb(0, 12'h000, 0); chk(q, 3);
			apb(1, 12'h008, 1); base = irqs; pulses(i == 2 ? 3 : 6, 8'h0a);
			apb(0, 12'h000, 0); chk(q, 1);
			chk(irqs - base, 1);
		end
		apb(1, 12'h000, 5); apb(0, 12'h000, 0); chk(q, 1);
		pulses(1, 8'h0a); apb(0, 12'h000, 0); chk(q, 5);
		apb(1, 12'h008, 0); pulses(2, 8'h0a); apb(0, 12'h000, 0); chk(q, 5);
		// Edge select none, then plain timer mode: running but nothing counts
		apb(1, 12'h004, 8'h0d); apb(1, 12'h008, 1); base = irqs; pulses(2, 8'h0a);
		apb(0, 12'h000, 0); chk(q, 5);
		apb(1, 12'h004, 0); pulses(2, 8'h0a); apb(0, 12'h000, 0); chk(q, 5);
		chk(irqs - base, 0);
	endtask
	// Period f1, width f1, period f8, f32, sub-clock/32: irqs, capture, writes
	logic [7:0] md[5] = '{8'h02, 8'h06, 8'h42, 8'h82, 8'hc2};
	int mk[5] = '{3, 2, 3, 3, 3}, mh[5] = '{10, 10, 40, 160, 255};
	int me[5] = '{2, 3, 2, 2, 2}, mlo[5] = '{19, 9, 9, 9, 1};
	task t_measure;
		for (int i = 0; i < 5; i++) begin
			apb(1, 12'h008, 0); apb(1, 12'h004, md[i]); apb(1, 12'h008, 1);
			base = irqs; pulses(mk[i], mh[i][7:0]); chk(irqs - base, me[i]);
			apb(0, 12'h000, 0); r = q; chk(q >= mlo[i] && q <= mlo[i] + 1, 1);
			apb(1, 12'h000, 32'h1234); apb(0, 12'h000, 0); chk(q, r);
		end
	endtask
	// Free count to overflow, then a mode write clears the flag
	task t_overflow;
		apb(1, 12'h008, 0); apb(1, 12'h004, 2); apb(1, 12'h008, 1); base = irqs;
		repeat (65560) @(posedge i_clock);
		chk(irqs - base, 1);
		apb(0, 12'h004, 0); chk(q[5], 1);
		apb(1, 12'h004, 2); apb(0, 12'h004, 0); chk(q[5], 0);
	endtask
	task stop_test;
		$display("tests %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clock);
		i_rst <= 0;
		t_reset; t_event; t_measure; t_overflow;
		stop_test;
	end
	// Whole run needs about 70k cycles
	initial begin
		repeat (90000) @(posedge i_clock);
		bad_count++;
		stop_test;
	end
endmodule // tb_timer_b_channel
`default_nettype wire
